// >>> hw/tme_defs.svh
// Constants of the two-wire mode engine: offsets, fields, reset values
`ifndef TME_DEFS_SVH
`define TME_DEFS_SVH
// ****************************************
// Register offsets
// ****************************************
`define TME_OFS_CTRL 4'h0
`define TME_OFS_TXD 4'h1
`define TME_OFS_RXD 4'h2
`define TME_OFS_STAT 4'h3
`define TME_OFS_BAUD 4'h4
// ****************************************
// Control fields
// ****************************************
`define TME_B_ENABLE 0
`define TME_B_START_REQUEST 1
`define TME_B_RSTREQ 2
`define TME_B_STOP_REQUEST 3
`define TME_B_GENSEL 4
`define TME_B_ARBBYTE 5
`define TME_B_ALS 6
`define TME_B_CSYNC 7
`define TME_B_WAIT 8
`define TME_B_CLOCK_RELEASE_ON_STOP 9
`define TME_B_FLOW 10
`define TME_B_CLOCK_PHASE_SELECT 11
`define TME_B_HOLD9 12
`define TME_B_DATA_OUTPUT_DISABLE 13
`define TME_B_LAYOUT 14
`define TME_B_DLY 15
`define TME_B_DEFSDA 18
`define TME_B_ACKVAL 19
// Default data level high at reset, so the data line stays released
`define TME_CTRL_RST 20'h40000
`define TME_BAUD_RST 8'h0f
`endif

// >>> hw/tme_pkg.sv
// Types of the two-wire mode engine
package tme_pkg;
   // Generator states
   typedef enum logic [5:0] {
      TME_G_IDLE = 6'h01,
      TME_G_SETUP = 6'h02,
      TME_G_DROP = 6'h04,
      TME_G_LOWCLK = 6'h08,
      TME_G_RISE = 6'h10,
      TME_G_DONE = 6'h20
   } tme_gen_t;
   // Condition events toward the interrupt controller
   typedef struct packed {
      logic cond;
      logic ack;
      logic nack;
      logic rx_done;
   } tme_evt_t;
   // Bus line drive, enable low means driving low
   typedef struct packed {
      logic scl_oe_n;
      logic sda_oe_n;
   } tme_pin_t;
endpackage

// >>> hw/tme_sync2.sv
// Two-flop synchroniser with edge flags taken from the second stage
module tme_sync2 import tme_pkg::*; (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire logic i_async,
   output logic o_lvl,
   output logic o_rise,
   output logic o_fall
);
   logic s1_q, s1_d, s2_q, s2_d, s3_q, s3_d;
   // Next values
   always_comb begin
      s1_d = i_async;
      s2_d = s1_q;
      s3_d = s2_q;
   end
   // Bus idles high, so reset to high
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         s1_q <= 1'b1;
         s2_q <= 1'b1;
         s3_q <= 1'b1;
      end else if (i_ce) begin
         s1_q <= s1_d;
         s2_q <= s2_d;
         s3_q <= s3_d;
      end
   end
   assign o_lvl = s2_q;
   assign o_rise = s2_q & ~s3_q;
   assign o_fall = ~s2_q & s3_q;
endmodule // tme_sync2

// >>> hw/tme_delay.sv
// Data-line output delay line, tapped by the delay field
module tme_delay import tme_pkg::*; #(
   parameter int DEPTH = 8
) (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire logic i_tick,
   input wire logic [2:0] i_sel,
   input wire logic i_din,
   output logic o_dout
);
   logic [DEPTH-1:0] sh_q, sh_d;
   initial begin
      if (DEPTH != 8) $error("tme_delay: DEPTH must be 8");
   end
   // Shift once per counter source tick
   always_comb begin
      sh_d = sh_q;
      if (i_tick) sh_d = {sh_q[DEPTH-2:0], i_din};
   end
   always_ff @(posedge i_mclk) begin
      if (i_rst) sh_q <= '1;
      else if (i_ce) sh_q <= sh_d;
   end
   assign o_dout = (i_sel == 3'h0) ? i_din : sh_q[i_sel];
endmodule // tme_delay

// >>> hw/tme_engine.sv
// Two-wire mode engine: conditions, arbitration, clock control, shifting
//
// The address map and the plain strobed port are this design's own decisions.
`include "tme_defs.svh"
module tme_engine import tme_pkg::*; (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire logic [3:0] i_addr,
   input wire logic [19:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [19:0] o_rdata,
   input wire logic i_bus_clock_pin,
   input wire logic i_bus_data_pin,
   output tme_pin_t o_pin,
   output logic o_scl_o,
   output logic o_sda_o,
   output tme_evt_t o_evt,
   output logic o_bus_busy_flag
);
   // ****************************************
   // Register file
   // ****************************************
   logic [19:0] ctrl_q, ctrl_d;
   logic [8:0] txd_q, txd_d;
   logic [7:0] baud_q, baud_d;
   logic [19:0] rdata_q, rdata_d;
   logic [8:0] rxbuf_q, rxbuf_d;
   logic arb_q, arb_d, mism_q, mism_d, busy_q, busy_d;
   logic scl_lvl, scl_rise, scl_fall, sda_lvl, sda_rise, sda_fall;
   logic start_det, stop_det, gen_done, gen_start, gen_stop;
   tme_gen_t gst_q, gst_d;
   logic gstop_q, gstop_d;
   logic iscl_q, iscl_d, hold_q, hold_d;
   logic [7:0] cnt_q, cnt_d;
   logic [3:0] bit_q, bit_d;
   logic [8:0] sh_q, sh_d;
   logic [8:0] rsh_q, rsh_d;
   logic tick, tclk, tclk_q, t_rise, t_fall, sda_raw, sda_dly;
   logic stop_seen_q, stop_seen_d;
   wire gen_sel = ctrl_q[`TME_B_GENSEL];
   wire layout = ctrl_q[`TME_B_LAYOUT];
   // Pins pass two flops first
   tme_sync2 u_scl (.i_mclk(i_mclk), .i_rst(i_rst), .i_ce(i_ce), .i_async(i_bus_clock_pin),
      .o_lvl(scl_lvl), .o_rise(scl_rise), .o_fall(scl_fall));
   tme_sync2 u_sda (.i_mclk(i_mclk), .i_rst(i_rst), .i_ce(i_ce), .i_async(i_bus_data_pin),
      .o_lvl(sda_lvl), .o_rise(sda_rise), .o_fall(sda_fall));
   assign start_det = sda_fall & scl_lvl;
   assign stop_det = sda_rise & scl_lvl;
   // Register writes; hardware clears the three request bits when generation is done
   always_comb begin
      ctrl_d = ctrl_q;
      txd_d = txd_q;
      baud_d = baud_q;
      rdata_d = 20'h00000;
      if (i_wr && i_addr == `TME_OFS_CTRL) ctrl_d = i_wdata;
      if (i_wr && i_addr == `TME_OFS_TXD) txd_d = i_wdata[8:0];
      if (i_wr && i_addr == `TME_OFS_BAUD) baud_d = i_wdata[7:0];
      if (gen_done) begin
         ctrl_d[`TME_B_START_REQUEST] = 1'b0;
         ctrl_d[`TME_B_RSTREQ] = 1'b0;
         ctrl_d[`TME_B_STOP_REQUEST] = 1'b0;
      end
      if (i_rd) begin
         unique case (i_addr)
            `TME_OFS_CTRL: rdata_d = ctrl_q;
            `TME_OFS_TXD: rdata_d = {11'h000, txd_q};
            // layout 1 with phase 1 after ninth rise reads standard order
            `TME_OFS_RXD: rdata_d = {arb_q, 10'h000, rxbuf_q};
            `TME_OFS_STAT: rdata_d = {17'h00000, gstop_q, busy_q, arb_q};
            `TME_OFS_BAUD: rdata_d = {12'h000, baud_q};
            default: rdata_d = 20'h00000;
         endcase
      end
   end
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         ctrl_q <= `TME_CTRL_RST;
         txd_q <= 9'h1ff;
         baud_q <= `TME_BAUD_RST;
         rdata_q <= 20'h00000;
      end else if (i_ce) begin
         ctrl_q <= ctrl_d;
         txd_q <= txd_d;
         baud_q <= baud_d;
         rdata_q <= rdata_d;
      end
   end
   assign o_rdata = rdata_q;
   // ****************************************
   // Condition generator
   // ****************************************
   // requests act only with the generator selected
   always_comb begin
      gst_d = gst_q;
      gstop_d = gstop_q;
      gen_done = 1'b0;
      unique case (gst_q)
         TME_G_IDLE: begin
            if (gen_sel && tick) begin
               if (ctrl_q[`TME_B_START_REQUEST] || ctrl_q[`TME_B_RSTREQ]) begin
                  gst_d = TME_G_SETUP;
                  gstop_d = 1'b0;
               end else if (ctrl_q[`TME_B_STOP_REQUEST]) begin
                  gst_d = TME_G_SETUP;
                  gstop_d = 1'b1;
               end
            end
         end
         TME_G_SETUP: if (tick) gst_d = TME_G_DROP;
         TME_G_DROP: if (tick) gst_d = TME_G_RISE;
         TME_G_RISE: if (tick) gst_d = gstop_q ? TME_G_DONE : TME_G_LOWCLK;
         TME_G_LOWCLK: if (tick) gst_d = TME_G_DONE;
         TME_G_DONE: begin
            gen_done = 1'b1;
            gst_d = TME_G_IDLE;
         end
         default: gst_d = TME_G_IDLE;
      endcase
   end
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         gst_q <= TME_G_IDLE;
         gstop_q <= 1'b0;
      end else if (i_ce) begin
         gst_q <= gst_d;
         gstop_q <= gstop_d;
      end
   end
   assign gen_start = gen_done & ~gstop_q;
   assign gen_stop = gen_done & gstop_q;
   // ****************************************
   // Baud counter and internal clock
   // ****************************************
   assign tick = (cnt_q == 8'h00);
   // transfer clock is internal AND pin
   assign tclk = iscl_q & scl_lvl;
   assign t_rise = tclk & ~tclk_q;
   assign t_fall = ~tclk & tclk_q;
   always_comb begin
      cnt_d = tick ? baud_q : cnt_q - 8'h01;
      iscl_d = iscl_q;
      if (tick && gst_q == TME_G_IDLE && busy_q) iscl_d = ~iscl_q;
      // Clock stays low after a generated start, else a false stop follows
      if (gen_start) iscl_d = 1'b0;
      if (ctrl_q[`TME_B_CSYNC]) begin
         // external fall pulls internal low and reloads
         if (scl_fall && iscl_q) begin
            iscl_d = 1'b0;
            cnt_d = baud_q;
         end else if (iscl_q && !scl_lvl) begin
            // Stretched by another party: counting waits
            cnt_d = cnt_q;
         end
      end
   end
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         cnt_q <= `TME_BAUD_RST;
         iscl_q <= 1'b1;
         tclk_q <= 1'b1;
      end else if (i_ce) begin
         cnt_q <= cnt_d;
         iscl_q <= iscl_d;
         tclk_q <= tclk;
      end
   end
   // ****************************************
   // Shifting, arbitration, holds
   // ****************************************
   always_comb begin
      bit_d = bit_q;
      sh_d = sh_q;
      rsh_d = rsh_q;
      rxbuf_d = rxbuf_q;
      arb_d = arb_q;
      mism_d = mism_q;
      busy_d = busy_q;
      hold_d = hold_q;
      stop_seen_d = stop_seen_q;
      o_evt = '0;
      if (i_wr && i_addr == `TME_OFS_STAT) arb_d = 1'b0;
      if (start_det || gen_start) begin
         busy_d = 1'b1;
         // A detected start's own clock fall is no bit end, so park the count
         bit_d = gen_start ? 4'h0 : 4'hf;
         sh_d = txd_q;
         stop_seen_d = 1'b0;
      end
      if (stop_det || gen_stop) begin
         busy_d = 1'b0;
         stop_seen_d = 1'b1;
      end
      // one shared event, busy flag tells which
      o_evt.cond = gen_sel ? gen_done : (start_det | stop_det);
      if (t_rise) begin
         rsh_d = {rsh_q[7:0], sda_lvl};
         if (bit_q < 4'h8 && !ctrl_q[`TME_B_ARBBYTE]) arb_d = (sh_q[8] != sda_lvl);
         if (bit_q < 4'h8 && sh_q[8] != sda_lvl) mism_d = 1'b1;
         if (bit_q == 4'h8) begin
            // standard layout with acknowledge in bit 8
            rxbuf_d = {sda_lvl, rsh_q[7:0]};
            if (!layout) begin
               o_evt.nack = sda_lvl;
               o_evt.ack = ~sda_lvl;
            end
            o_evt.rx_done = 1'b1;
         end
      end
      if (t_fall && bit_q == 4'hf) begin
         bit_d = 4'h0;
      end else if (t_fall) begin
         sh_d = {sh_q[7:0], 1'b1};
         bit_d = bit_q + 4'h1;
         if (bit_q == 4'h7 && layout) rxbuf_d = {rsh_q[0], 1'b0, rsh_q[7:1]};
         if (bit_q == 4'h8) begin
            if (ctrl_q[`TME_B_ARBBYTE] && mism_q) arb_d = 1'b1;
            mism_d = 1'b0;
            bit_d = 4'h0;
            sh_d = txd_q;
            if (ctrl_q[`TME_B_WAIT] || (ctrl_q[`TME_B_CLOCK_PHASE_SELECT] && ctrl_q[`TME_B_HOLD9])) hold_d = 1'b1;
         end
      end
      if (!ctrl_q[`TME_B_WAIT] && !(ctrl_q[`TME_B_CLOCK_PHASE_SELECT] && ctrl_q[`TME_B_HOLD9])) hold_d = 1'b0;
      if (bit_q == 4'h8 && !t_fall) sh_d[8] = ctrl_q[`TME_B_ACKVAL];
   end
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         bit_q <= 4'h0;
         sh_q <= 9'h1ff;
         rsh_q <= 9'h000;
         rxbuf_q <= 9'h000;
         arb_q <= 1'b0;
         mism_q <= 1'b0;
         busy_q <= 1'b0;
         hold_q <= 1'b0;
         stop_seen_q <= 1'b0;
      end else if (i_ce) begin
         bit_q <= bit_d;
         sh_q <= sh_d;
         rsh_q <= rsh_d;
         rxbuf_q <= rxbuf_d;
         arb_q <= arb_d;
         mism_q <= mism_d;
         busy_q <= busy_d;
         hold_q <= hold_d;
         stop_seen_q <= stop_seen_d;
      end
   end
   assign o_bus_busy_flag = busy_q;
   // ****************************************
   // Pin drive
   // ****************************************
   // Default level stands while disabled
   assign sda_raw = !ctrl_q[`TME_B_ENABLE] ? ctrl_q[`TME_B_DEFSDA] :
      (gst_q == TME_G_DROP || gst_q == TME_G_LOWCLK) ? 1'b0 :
      (gst_q == TME_G_SETUP) ? ~gstop_q : (gst_q == TME_G_RISE) ? gstop_q : sh_q[8];
   tme_delay #(.DEPTH(8)) u_dly (.i_mclk(i_mclk), .i_rst(i_rst), .i_ce(i_ce), .i_tick(tick),
      .i_sel(ctrl_q[`TME_B_DLY +: 3]), .i_din(sda_raw), .o_dout(sda_dly));
   assign o_scl_o = 1'b0;
   assign o_sda_o = 1'b0;
   always_comb begin
      o_pin.sda_oe_n = sda_dly;
      o_pin.scl_oe_n = iscl_q && !hold_q && !(gst_q == TME_G_LOWCLK)
         && !(gst_q == TME_G_DONE && !gstop_q);
      if (ctrl_q[`TME_B_ALS] && arb_q) o_pin.sda_oe_n = 1'b1;
      if (ctrl_q[`TME_B_DATA_OUTPUT_DISABLE]) o_pin.sda_oe_n = 1'b1;
      if (ctrl_q[`TME_B_FLOW]) o_pin.scl_oe_n = 1'b0;
      if (ctrl_q[`TME_B_CLOCK_RELEASE_ON_STOP] && stop_seen_q) o_pin.scl_oe_n = 1'b1;
   end
   // ****************************************
   // Assertions
   // ****************************************
   a_start_evt: assert property (@(posedge i_mclk) disable iff (i_rst)
      (i_ce && start_det) |=> busy_q) else $error("start not flagged busy");
   a_stop_evt: assert property (@(posedge i_mclk) disable iff (i_rst)
      (i_ce && stop_det && !start_det) |=> !busy_q) else $error("stop left busy set");
   a_cond_src: assert property (@(posedge i_mclk) disable iff (i_rst)
      (!gen_sel && start_det) |-> o_evt.cond) else $error("detect event missing");
   a_arb_bit: assert property (@(posedge i_mclk) disable iff (i_rst)
      (i_ce && t_rise && bit_q < 4'h8 && !ctrl_q[`TME_B_ARBBYTE] && !i_wr
      && sh_q[8] != sda_lvl) |=> arb_q) else $error("bit loss not set");
   a_als_rel: assert property (@(posedge i_mclk) disable iff (i_rst)
      (ctrl_q[`TME_B_ALS] && arb_q) |-> o_pin.sda_oe_n) else $error("data not released");
   a_data_output_disable_rel: assert property (@(posedge i_mclk) disable iff (i_rst)
      ctrl_q[`TME_B_DATA_OUTPUT_DISABLE] |-> o_pin.sda_oe_n) else $error("data not disabled");
   a_flow_hold: assert property (@(posedge i_mclk) disable iff (i_rst)
      (ctrl_q[`TME_B_FLOW] && !(ctrl_q[`TME_B_CLOCK_RELEASE_ON_STOP] && stop_seen_q)) |-> !o_pin.scl_oe_n)
      else $error("clock not forced low");
   a_and_clk: assert property (@(posedge i_mclk) disable iff (i_rst)
      tclk == (iscl_q && scl_lvl)) else $error("transfer clock wrong");
endmodule // tme_engine

// >>> tb/tme_bus_peer.sv
// Other party on the two-wire bus: pull-ups plus a second master's drive
module tme_bus_peer #(
   parameter int HALF_NS = 40
) (
   input wire logic i_scl_oe_n,
   input wire logic i_sda_oe_n,
   output logic o_scl,
   output logic o_sda
);
   timeunit 1ns;
   timeprecision 1ps;
   // Own drive, 1 means released
   logic drv_scl = 1'b1;
   logic drv_sda = 1'b1;
   assign o_scl = drv_scl & i_scl_oe_n;
   assign o_sda = drv_sda & i_sda_oe_n;
   task automatic send_start();
      drv_sda = 1'b0;
      #(HALF_NS);
      drv_scl = 1'b0;
   endtask
   task automatic send_bit(input logic b);
      #(HALF_NS / 2);
      drv_sda = b;
      #(HALF_NS / 2);
      drv_scl = 1'b1;
      wait (o_scl === 1'b1);
      #(HALF_NS);
      drv_scl = 1'b0;
   endtask
   task automatic send_byte(input logic [7:0] b, input logic ack);
      for (int i = 7; i >= 0; i--) begin
         send_bit(b[i]);
      end
      send_bit(ack);
   endtask
   // stop, clock high; clock may be stretched before it rises
   task automatic send_stop();
      #(HALF_NS / 2);
      drv_sda = 1'b0;
      #(HALF_NS);
      drv_scl = 1'b1;
      wait (o_scl === 1'b1);
      #(HALF_NS);
      drv_sda = 1'b1;
   endtask
endmodule // tme_bus_peer

// >>> tb/uart_i2c_mode_engine_bench.sv
// Self-checking bench of the two-wire mode engine against a bus peer
`include "tme_defs.svh"
module uart_i2c_mode_engine_bench import tme_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   // ****************************************
   // Signals
   // ****************************************
   logic i_mclk;
   logic i_rst;
   logic [3:0] i_addr;
   logic [19:0] i_wdata;
   logic i_wr;
   logic i_rd;
   logic [19:0] o_rdata;
   tme_pin_t pin;
   tme_evt_t evt;
   logic busy;
   logic bus_scl;
   logic bus_sda;
   int failures = 0;
   int compares = 0;
   int cond_cnt = 0;
   int ack_cnt = 0;
   int nack_cnt = 0;
   int c0;
   logic i_ce;
   logic scl_o;
   logic sda_o;
   logic [19:0] rd_val;
   // Enable, sync, default data high, ack value high
   localparam logic [19:0] CTRL_RX = 20'hc0081;
   // Enable, default data high, ack value high
   localparam logic [19:0] CTRL_PLAIN = 20'hc0001;
   // ****************************************
   // Block and far side
   // ****************************************
   tme_engine uut (.i_mclk(i_mclk), .i_rst(i_rst), .i_ce(i_ce), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .i_bus_clock_pin(bus_scl), .i_bus_data_pin(bus_sda), .o_pin(pin),
      .o_scl_o(scl_o), .o_sda_o(sda_o), .o_evt(evt), .o_bus_busy_flag(busy));
   tme_bus_peer #(.HALF_NS(40)) peer (.i_scl_oe_n(pin.scl_oe_n), .i_sda_oe_n(pin.sda_oe_n),
      .o_scl(bus_scl), .o_sda(bus_sda));
   // Clock
   initial begin
      i_mclk = 1'b0;
      forever #5 i_mclk = ~i_mclk;
   end
   // Event pulses counted at the edge where they stand
   always @(posedge i_mclk) begin
      if (!i_rst && evt.cond) cond_cnt++;
      if (!i_rst && evt.ack) ack_cnt++;
      if (!i_rst && evt.nack) nack_cnt++;
   end
   // ****************************************
   // Helpers
   // ****************************************
   task automatic check(input logic [19:0] got, input logic [19:0] exp, input string msg);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: %s", $time, msg);
      end
   endtask
   task automatic wait_cycles(input int n);
      repeat (n) @(posedge i_mclk);
      #1;
   endtask
   task automatic reg_wr(input logic [3:0] a, input logic [19:0] d);
      @(posedge i_mclk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_mclk);
      i_wr <= 1'b0;
   endtask
   // Data stand in the cycle after the strobe
   task automatic reg_rd(input logic [3:0] a, output logic [19:0] d);
      @(posedge i_mclk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      #1;
      d = o_rdata;
   endtask
   task automatic tally_and_finish();
      $display("counts: %0d compares, %0d failures", compares, failures);
      if (failures == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic test_reset();
      wait_cycles(1);
      check({18'h00000, pin}, 20'h00003, "lines not released");
      check({18'h00000, scl_o, sda_o}, 20'h00000, "drive level not low");
      check({19'h00000, busy}, 20'h00000, "busy after reset");
      reg_rd(`TME_OFS_CTRL, rd_val);
      check(rd_val, `TME_CTRL_RST, "ctrl reset value");
      reg_rd(`TME_OFS_BAUD, rd_val);
      check(rd_val, {12'h000, `TME_BAUD_RST}, "baud reset value");
      $display("test_reset done");
   endtask
   task automatic test_regs();
      reg_wr(`TME_OFS_TXD, 20'h001ff);
      reg_rd(`TME_OFS_TXD, rd_val);
      check(rd_val, 20'h001ff, "txd readback");
      // Frozen clock enable must drop the write
      @(posedge i_mclk);
      i_ce <= 1'b0;
      reg_wr(`TME_OFS_BAUD, 20'h00003);
      @(posedge i_mclk);
      i_ce <= 1'b1;
      reg_rd(`TME_OFS_BAUD, rd_val);
      check(rd_val, {12'h000, `TME_BAUD_RST}, "write landed while frozen");
      reg_wr(`TME_OFS_CTRL, 20'h40000);
      wait_cycles(2);
      check({19'h00000, pin.sda_oe_n}, 20'h00001, "default level not high");
      $display("test_regs done");
   endtask
   task automatic test_rx_bytes();
      reg_wr(`TME_OFS_CTRL, CTRL_RX);
      peer.send_start();
      wait_cycles(2);
      check({19'h00000, busy}, 20'h00001, "start not seen");
      check(20'(cond_cnt), 20'h00001, "start event count");
      peer.send_byte(8'h5a, 1'b0);
      wait_cycles(2);
      reg_rd(`TME_OFS_RXD, rd_val);
      check(rd_val, 20'h8005a, "first byte layout");
      check(20'(ack_cnt), 20'h00001, "ack event count");
      reg_rd(`TME_OFS_STAT, rd_val);
      check(rd_val, 20'h00003, "bit loss flag");
      reg_wr(`TME_OFS_STAT, 20'h00000);
      reg_rd(`TME_OFS_STAT, rd_val);
      check(rd_val, 20'h00002, "loss flag not cleared");
      peer.send_byte(8'ha5, 1'b1);
      wait_cycles(2);
      reg_rd(`TME_OFS_RXD, rd_val);
      check(rd_val, 20'h001a5, "second byte layout");
      check(20'(nack_cnt), 20'h00001, "nack event count");
      peer.send_stop();
      wait_cycles(4);
      check({19'h00000, busy}, 20'h00000, "stop not seen");
      check(20'(cond_cnt), 20'h00002, "stop event count");
      $display("test_rx_bytes done");
   endtask
   task automatic test_clock_ctrl();
      reg_wr(`TME_OFS_CTRL, CTRL_PLAIN | 20'h00400);
      wait_cycles(3);
      check({19'h00000, pin.scl_oe_n}, 20'h00000, "clock not forced");
      reg_wr(`TME_OFS_CTRL, CTRL_PLAIN | 20'h02400);
      wait_cycles(3);
      check({19'h00000, pin.sda_oe_n}, 20'h00001, "data not disabled");
      reg_wr(`TME_OFS_CTRL, CTRL_PLAIN | 20'h00600);
      wait_cycles(3);
      check({19'h00000, pin.scl_oe_n}, 20'h00001, "clock held after stop");
      reg_wr(`TME_OFS_CTRL, CTRL_PLAIN);
      wait_cycles(3);
      check({19'h00000, pin.scl_oe_n}, 20'h00001, "clock not restored");
      $display("test_clock_ctrl done");
   endtask
   task automatic test_gen_start();
      c0 = cond_cnt;
      reg_wr(`TME_OFS_CTRL, CTRL_PLAIN | 20'h00002);
      reg_wr(`TME_OFS_CTRL, CTRL_PLAIN | 20'h00012);
      wait_cycles(200);
      check(20'(cond_cnt - c0), 20'h00001, "generation event");
      check({19'h00000, busy}, 20'h00001, "generated start not busy");
      reg_rd(`TME_OFS_CTRL, rd_val);
      check(rd_val, CTRL_PLAIN | 20'h00010, "request not cleared");
      $display("test_gen_start done");
   endtask
   task automatic test_mid_reset();
      @(posedge i_mclk);
      i_rst <= 1'b1;
      repeat (2) @(posedge i_mclk);
      i_rst <= 1'b0;
      wait_cycles(1);
      check({18'h00000, pin}, 20'h00003, "lines after reset");
      check({19'h00000, busy}, 20'h00000, "busy after reset");
      reg_rd(`TME_OFS_CTRL, rd_val);
      check(rd_val, `TME_CTRL_RST, "ctrl after reset");
      $display("test_mid_reset done");
   endtask
   // ****************************************
   // Sequence and watchdog
   // ****************************************
   initial begin
      i_rst <= 1'b1;
      i_ce <= 1'b1;
      i_wr <= 1'b0;
      i_rd <= 1'b0;
      i_addr <= 4'h0;
      i_wdata <= 20'h00000;
      repeat (4) @(posedge i_mclk);
      i_rst <= 1'b0;
      test_reset();
      test_regs();
      test_rx_bytes();
      test_clock_ctrl();
      test_gen_start();
      test_mid_reset();
      tally_and_finish();
   end
   // Tests need under 1000 cycles; 20000 cycles without finishing is a hang
   initial begin
      #200000;
      failures++;
      $display("wrong value at %0t: watchdog expired", $time);
      tally_and_finish();
   end
endmodule // uart_i2c_mode_engine_bench
